// >>> logic/tmc_timer.sv
// split 8-bit / 16-bit timer with external oscillator capture, APB registers
// assumes one 50 MHz clock, synchronous reset, external clock as a plain input
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "tmc_defs.svh"

module tmc_timer
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_ext_clock,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq
);

	tmc_pkg::tmc_ctrl_t ctrl_r;
	tmc_pkg::tmc_ctrl_t ctrl_nxt;
	tmc_pkg::tmc_word_t count_r;
	tmc_pkg::tmc_word_t count_nxt;
	tmc_pkg::tmc_word_t reload_r;
	tmc_pkg::tmc_word_t reload_nxt;
	logic [`TMC_ST_WIDTH-1:0] status_r;
	logic [`TMC_ST_WIDTH-1:0] status_nxt;
	logic [`TMC_ST_WIDTH-1:0] mask_r;
	logic [`TMC_ST_WIDTH-1:0] mask_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic irq_r;
	logic irq_nxt;

	logic sys12_tick;
	logic ext_tick;
	logic capture_evt;
	tmc_pkg::tmc_events_t evt;
	logic hi_en;
	logic lo_en;
	logic lo_wrap;
	logic hi_wrap;
	logic access;
	logic wr;
	logic mapped;

	tmc_prescaler u_prescaler
	(
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.o_tick(sys12_tick)
	);

	tmc_ext_edge u_ext_edge
	(
		.i_clock(i_clock),
		.i_sys_rst(i_sys_rst),
		.i_ext_clock(i_ext_clock),
		.o_ext_tick(ext_tick),
		.o_capture(capture_evt)
	);

	// count enables per byte
	always_comb
	begin
		if (ctrl_r.hi_system_clock_in)
			hi_en = 1'b1;
		else if (ctrl_r.ext_sel)
			hi_en = ext_tick;
		else
			hi_en = sys12_tick;
		if (ctrl_r.lo_system_clock_in)
			lo_en = 1'b1;
		else if (ctrl_r.ext_sel && !ctrl_r.capture)
			lo_en = ext_tick;
		else
			lo_en = sys12_tick;
		hi_en = hi_en && ctrl_r.run;
		lo_en = lo_en && ctrl_r.run;
	end

	assign access = i_psel && i_penable && !pready_r;
	assign wr = access && i_pwrite;
	assign mapped = (i_paddr == `TMC_OFF_CTRL) || (i_paddr == `TMC_OFF_COUNT)
		|| (i_paddr == `TMC_OFF_RELOAD) || (i_paddr == `TMC_OFF_STATUS)
		|| (i_paddr == `TMC_OFF_MASK) || (i_paddr == `TMC_OFF_ID);

	// counter, reload and capture
	always_comb
	begin
		count_nxt = count_r;
		reload_nxt = reload_r;
		lo_wrap = 1'b0;
		hi_wrap = 1'b0;
		if (ctrl_r.split && !ctrl_r.capture)
		begin
			// two independent bytes, each with its own source
			if (lo_en)
			begin
				count_nxt.lo = count_r.lo + 8'h01;
				lo_wrap = (count_r.lo == 8'hFF);
			end
			if (hi_en)
			begin
				count_nxt.hi = count_r.hi + 8'h01;
				hi_wrap = (count_r.hi == 8'hFF);
			end
		end
		else if (lo_en)
		begin
			// 16-bit: low byte source drives the whole count
			count_nxt.lo = count_r.lo + 8'h01;
			lo_wrap = (count_r.lo == 8'hFF);
			if (lo_wrap)
			begin
				count_nxt.hi = count_r.hi + 8'h01;
				hi_wrap = (count_r.hi == 8'hFF);
			end
			// auto-reload on full wrap, only outside capture
			if (hi_wrap && !ctrl_r.capture)
				count_nxt = reload_r;
		end
		if (ctrl_r.capture && capture_evt)
			reload_nxt = count_r;
		if (wr && i_paddr == `TMC_OFF_COUNT)
			count_nxt = i_pwdata[15:0];
		if (wr && i_paddr == `TMC_OFF_RELOAD)
			reload_nxt = i_pwdata[15:0];
		// a capture in the same cycle as a reload write wins
		if (ctrl_r.capture && capture_evt)
			reload_nxt = count_r;
	end

	always_comb
	begin
		evt.hi_ovf = hi_wrap || (ctrl_r.capture && capture_evt);
		evt.lo_ovf = lo_wrap;
		evt.capture = ctrl_r.capture && capture_evt;
	end

	// control, status, mask and bus answer
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		prdata_nxt = prdata_r;
		pready_nxt = access;
		pslverr_nxt = access && !mapped;
		if (wr && i_paddr == `TMC_OFF_CTRL)
			ctrl_nxt = i_pwdata[`TMC_CTRL_WIDTH-1:0];
		if (wr && i_paddr == `TMC_OFF_MASK)
			mask_nxt = i_pwdata[`TMC_ST_WIDTH-1:0];
		// write-one-to-clear only; hardware never clears
		if (wr && i_paddr == `TMC_OFF_STATUS)
			status_nxt = status_r & ~i_pwdata[`TMC_ST_WIDTH-1:0];
		status_nxt = status_nxt | evt;
		if (access && !i_pwrite)
		begin
			unique case (i_paddr)
				`TMC_OFF_CTRL: prdata_nxt = {24'h00_0000, ctrl_r};
				`TMC_OFF_COUNT: prdata_nxt = {16'h0000, count_r};
				`TMC_OFF_RELOAD: prdata_nxt = {16'h0000, reload_r};
				`TMC_OFF_STATUS: prdata_nxt = {29'h000_0000, status_r};
				`TMC_OFF_MASK: prdata_nxt = {29'h000_0000, mask_r};
				`TMC_OFF_ID: prdata_nxt = `TMC_ID_VALUE;
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// interrupt line
	always_comb
	begin
		// low flag reaches the line only with its own enable
		irq_nxt = ctrl_r.irq_en && (
			(status_r[`TMC_ST_HI_OVF] && mask_r[`TMC_ST_HI_OVF])
			|| (ctrl_r.lo_irq_en && status_r[`TMC_ST_LO_OVF]
				&& mask_r[`TMC_ST_LO_OVF])
			|| (status_r[`TMC_ST_CAPTURE] && mask_r[`TMC_ST_CAPTURE]));
	end

	// counter and reload registers
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			count_r <= 16'h0000;
			reload_r <= 16'h0000;
		end
		else
		begin
			count_r <= count_nxt;
			reload_r <= reload_nxt;
		end
	end

	// software-visible control, mask and sticky flags
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			ctrl_r <= `TMC_CTRL_RESET;
			status_r <= 3'h0;
			mask_r <= `TMC_MASK_RESET;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
		end
	end

	// bus answer: registered, so it stands one cycle after the access edge
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// registered line, so flag and mask updates never glitch the output
	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
			irq_r <= 1'b0;
		else
			irq_r <= irq_nxt;
	end

	assign o_prdata = prdata_r;
	assign o_pready = pready_r;
	assign o_pslverr = pslverr_r;
	assign o_irq = irq_r;

endmodule

// >>> shared/tmc_defs.svh
// constants for the split/capture timer: register offsets, fields, reset values, divide counts
// assumes an APB slave with 32-bit data and word-aligned registers
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

`define TMC_OFF_CTRL 12'h000
`define TMC_OFF_COUNT 12'h004
`define TMC_OFF_RELOAD 12'h008
`define TMC_OFF_STATUS 12'h00C
`define TMC_OFF_MASK 12'h010
`define TMC_OFF_ID 12'h014

// control register fields
`define TMC_CTRL_RUN 0
`define TMC_CTRL_SPLIT 1
`define TMC_CTRL_CAPTURE 2
`define TMC_CTRL_HI_SYSTEM_CLOCK_IN 3
`define TMC_CTRL_LO_SYSTEM_CLOCK_IN 4
`define TMC_CTRL_EXT_SEL 5
`define TMC_CTRL_LO_IRQ_EN 6
`define TMC_CTRL_IRQ_EN 7
`define TMC_CTRL_WIDTH 8
`define TMC_CTRL_RESET 8'h00

// status / mask fields
`define TMC_ST_HI_OVF 0
`define TMC_ST_LO_OVF 1
`define TMC_ST_CAPTURE 2
`define TMC_ST_WIDTH 3
`define TMC_MASK_RESET 3'h7

// clock prescale figures
`define TMC_SYS_DIV 12
`define TMC_SYS_DIV_W 4
`define TMC_EXT_DIV 8
`define TMC_EXT_DIV_W 3

// identity value, arbitrary
`define TMC_ID_VALUE 32'h0000_0A5C

`endif

// >>> shared/tmc_pkg.sv
// types for the split/capture timer
// assumes tmc_defs.svh for the numeric constants
package tmc_pkg;

	typedef struct packed {
		logic irq_en;
		logic lo_irq_en;
		logic ext_sel;
		logic lo_system_clock_in;
		logic hi_system_clock_in;
		logic capture;
		logic split;
		logic run;
	} tmc_ctrl_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} tmc_word_t;

	typedef struct packed {
		logic capture;
		logic lo_ovf;
		logic hi_ovf;
	} tmc_events_t;

	typedef enum logic [2:0] {
		TMC_ACC_IDLE = 3'b001,
		TMC_ACC_SETUP = 3'b010,
		TMC_ACC_ACCESS = 3'b100
	} tmc_apb_state_t;

endpackage

// >>> logic/tmc_prescaler.sv
// system clock divide-by-12 enable generator
// assumes one system clock; emits a one-cycle enable pulse per 12 clocks
`timescale 1ns/1ps
`include "tmc_defs.svh"

module tmc_prescaler
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	output logic o_tick
);

	logic [`TMC_SYS_DIV_W-1:0] count_r;
	logic [`TMC_SYS_DIV_W-1:0] count_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb
	begin
		tick_nxt = 1'b0;
		count_nxt = count_r + 4'h1;
		if (count_r == 4'(`TMC_SYS_DIV - 1))
		begin
			count_nxt = 4'h0;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			count_r <= 4'h0;
			tick_r <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_tick = tick_r;

endmodule

// >>> logic/tmc_ext_edge.sv
// external oscillator divide-by-8 and falling-edge detector
// assumes the external clock is asynchronous; two flops synchronise its level before edge detection
`timescale 1ns/1ps
`include "tmc_defs.svh"

module tmc_ext_edge
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_ext_clock,
	output logic o_ext_tick,
	output logic o_capture
);

	logic [1:0] sync_r;
	logic [1:0] sync_nxt;
	logic prev_r;
	logic prev_nxt;
	logic [`TMC_EXT_DIV_W-1:0] div_r;
	logic [`TMC_EXT_DIV_W-1:0] div_nxt;
	logic div_prev_r;
	logic div_prev_nxt;
	logic tick_r;
	logic tick_nxt;
	logic cap_r;
	logic cap_nxt;

	always_comb
	begin
		sync_nxt = {sync_r[0], i_ext_clock};
		prev_nxt = sync_r[1];
		div_nxt = div_r;
		tick_nxt = 1'b0;
		// divide on rising edges of the synchronised clock
		if (sync_r[1] && !prev_r)
		begin
			div_nxt = div_r + 3'h1;
			tick_nxt = (div_r == 3'(`TMC_EXT_DIV - 1));
		end
		div_prev_nxt = div_r[`TMC_EXT_DIV_W-1];
		// msb of the divider is the clock/8 waveform; its fall marks capture
		cap_nxt = div_prev_r && !div_r[`TMC_EXT_DIV_W-1];
	end

	always_ff @(posedge i_clock)
	begin
		if (i_sys_rst)
		begin
			sync_r <= 2'b00;
			prev_r <= 1'b0;
			div_r <= 3'h0;
			div_prev_r <= 1'b0;
			tick_r <= 1'b0;
			cap_r <= 1'b0;
		end
		else
		begin
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
			div_r <= div_nxt;
			div_prev_r <= div_prev_nxt;
			tick_r <= tick_nxt;
			cap_r <= cap_nxt;
		end
	end

	assign o_ext_tick = tick_r;
	assign o_capture = cap_r;

endmodule

// >>> test/tmc_timer_props.sv
// port checker for tmc_timer: apb reply timing, error reply, irq release
// assumes it is bound to every tmc_timer instance
`timescale 1ns/1ps
module tmc_timer_props
(
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_irq
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);
	chk_ready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
		else $error("no reply after access");
	chk_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("reply too long");
	chk_ready_cause: assert property (o_pready |-> $past(i_psel && i_penable))
		else $error("reply without access");
	chk_err_pair: assert property (o_pslverr |-> o_pready)
		else $error("error without reply");
	chk_err_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000)
		else $error("refused read not zero");
	chk_map_ok: assert property (o_pready && i_paddr <= 12'h014 && i_paddr[1:0] == 2'b00
		|-> !o_pslverr) else $error("mapped place refused");
	chk_idle_quiet: assert property (!i_psel |-> !o_pready && !o_pslverr)
		else $error("reply while idle");
	chk_flag_sticky: assert property ($fell(o_irq) |->
		$past(i_psel && i_pwrite) || $past(i_psel && i_pwrite, 2))
		else $error("irq dropped without a write");
endmodule
bind tmc_timer tmc_timer_props chk_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq));

// >>> test/tmc_osc_model.sv
// external oscillator stand-in: square wave, half period in 20 ns steps
// assumes the bench picks the half period; off-grid start keeps it unrelated to the clock
`timescale 1ns/1ps
module tmc_osc_model
(
	input wire logic i_run,
	input wire logic [7:0] i_half,
	output logic o_ext_clock
);
	initial
	begin
		o_ext_clock = 1'b0;
		#3;
		forever
		begin
			#(20 * i_half);
			o_ext_clock = i_run ? ~o_ext_clock : 1'b0;
		end
	end
endmodule

// >>> test/tmc_timer_tb_top.sv
// bench for tmc_timer: apb master tasks, read-result queue, oscillator model
// assumes the offsets and fields of tmc_defs.svh
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_timer_tb_top;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	logic i_clock, i_sys_rst, i_psel, i_penable, i_pwrite, ext_clock, o_pready, o_pslverr, o_irq;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rv;
	logic [15:0] r1;
	logic [7:0] half;
	logic osc_run;
	logic [64:0] expq[$];
	logic [64:0] e;
	int err_total, tests_run, t;
	tmc_timer dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_ext_clock(ext_clock),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .o_irq(o_irq));
	tmc_osc_model osc_u (.i_run(osc_run), .i_half(half), .o_ext_clock(ext_clock));
	initial
	begin
		i_clock = 1'b0;
		forever
			#10 i_clock = ~i_clock;
	end
	task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] got);
	begin
		tests_run++;
		if (got !== ex)
		begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, ex, got);
		end
	end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	begin
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		do
			@(posedge i_clock);
		while (o_pready !== 1'b1);
		rv = o_prdata;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clock);
	end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// a zero mask still checks the error reply
	task automatic rd(input logic [11:0] a, input logic [31:0] ev, input logic [31:0] m);
	begin
		expq.push_back({a > 12'h014, ev & m, m});
		apb(1'b0, a, ZERO);
	end
	endtask
	always @(posedge i_clock)
		if (o_pready === 1'b1 && i_pwrite === 1'b0)
		begin
			e = expq.pop_front();
			chk("read", {e[64], e[63:32]}, {o_pslverr, o_prdata & e[31:0]});
		end
	task automatic end_sim();
	begin
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	initial
	begin
		#1_000_000;
		err_total++;
		end_sim();
	end
	initial
	begin
		err_total = 0;
		tests_run = 0;
		{i_sys_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {4'h8, 12'h000, ZERO};
		osc_run = 1'b0;
		void'($urandom(32'hf476));
		half = 8'(6 + 3 * ($urandom % 3));
		repeat (12) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		@(posedge i_clock);
		rd(`TMC_OFF_CTRL, ZERO, ALL);
		rd(`TMC_OFF_COUNT, ZERO, ALL);
		rd(`TMC_OFF_RELOAD, ZERO, ALL);
		rd(`TMC_OFF_STATUS, ZERO, ALL);
		rd(`TMC_OFF_MASK, 32'h0000_0007, ALL);
		rd(`TMC_OFF_ID, `TMC_ID_VALUE, ALL);
		rd(12'h018 + 12'(4 * ($urandom % 8)), ZERO, ALL);
		osc_run <= 1'b1;
		// sources in turn: system_clock_in, system_clock_in/12, ext/8, both bytes alike
		for (int s = 0; s < 3; s++)
		begin
			t = (s == 0) ? 1 : (s == 1) ? 12 : 16 * half;
			wr(`TMC_OFF_CTRL, ZERO);
			wr(`TMC_OFF_STATUS, 32'h0000_0007);
			wr(`TMC_OFF_COUNT, 32'h0000_F0F0);
			wr(`TMC_OFF_CTRL, (s == 0) ? 32'h0000_001B : (s == 1) ? 32'h0000_0003 : 32'h0000_0023);
			repeat (15 * t - 6) @(posedge i_clock);
			rd(`TMC_OFF_STATUS, ZERO, 32'h0000_0003);
			repeat (t + 18) @(posedge i_clock);
			rd(`TMC_OFF_STATUS, 32'h0000_0003, 32'h0000_0003);
		end
		wr(`TMC_OFF_CTRL, ZERO);
		osc_run <= 1'b0;
		repeat (300) @(posedge i_clock);
		rd(`TMC_OFF_STATUS, 32'h0000_0003, 32'h0000_0003);
		wr(`TMC_OFF_STATUS, 32'h0000_0001);
		rd(`TMC_OFF_STATUS, 32'h0000_0002, 32'h0000_0003);
		wr(`TMC_OFF_STATUS, 32'h0000_0007);
		// a set mask bit lets its flag through to the line, the low flag only with lo_irq_en set as well
		wr(`TMC_OFF_MASK, 32'h0000_0003);
		wr(`TMC_OFF_COUNT, 32'h0000_F0F0);
		wr(`TMC_OFF_CTRL, 32'h0000_0093);
		repeat (40) @(posedge i_clock);
		chk("irq", 33'h0, 33'(o_irq));
		wr(`TMC_OFF_CTRL, 32'h0000_00D3);
		@(posedge i_clock);
		chk("irq", 33'h1, 33'(o_irq));
		wr(`TMC_OFF_MASK, 32'h0000_0001);
		@(posedge i_clock);
		chk("irq", 33'h0, 33'(o_irq));
		repeat (200) @(posedge i_clock);
		chk("irq", 33'h1, 33'(o_irq));
		wr(`TMC_OFF_CTRL, ZERO);
		wr(`TMC_OFF_STATUS, 32'h0000_0007);
		@(posedge i_clock);
		chk("irq", 33'h0, 33'(o_irq));
		osc_run <= 1'b1;
		// gap between two captures is 8 ext periods of counts
		for (int s = 0; s < 2; s++)
		begin
			wr(`TMC_OFF_CTRL, s ? 32'h0000_0005 : 32'h0000_0015);
			for (int k = 0; k < 2; k++)
			begin
				wr(`TMC_OFF_STATUS, 32'h0000_0007);
				do
					rd(`TMC_OFF_STATUS, ZERO, ZERO);
				while (rv[0] !== 1'b1);
				rd(`TMC_OFF_STATUS, 32'h0000_0005, 32'h0000_0005);
				rd(`TMC_OFF_RELOAD, ZERO, ZERO);
				if (k == 0)
					r1 = rv[15:0];
			end
			chk("gap", 33'(16 * half / (s ? 12 : 1)), 33'(16'(rv[15:0] - r1)));
		end
		chk("queue", 33'h0, 33'(expq.size()));
		end_sim();
	end
endmodule
